// ==== rtl/pmc_regs.svh ====
// register indexes, field positions, reset values and timing for port mode control
`ifndef PMC_REGS_SVH
`define PMC_REGS_SVH

`define PMC_IDX_MIDSPAN 8'h11
`define PMC_IDX_MODE 8'h12
`define PMC_IDX_ENABLE 8'h14
`define PMC_IDX_PWRCMD 8'h19
`define PMC_IDX_PRESET 8'h1A
`define PMC_IDX_HICAP 8'h23
`define PMC_IDX_STATUS 8'h30

`define PMC_BIT_MIDSPAN 1
`define PMC_BIT_SWRST 4
`define PMC_BIT_BYPASS 4

`define PMC_MODE_SHUT 2'h0
`define PMC_MODE_MANUAL 2'h1
`define PMC_MODE_SEMI 2'h2
`define PMC_MODE_AUTO 2'h3

`define PMC_I2C_ADDR_HI 3'h2
`define PMC_RST_STRETCH 3'h7

`define PMC_CLK_KHZ 40000
`define PMC_CAD_MIN_MS 2000
`define PMC_CAD_MAX_MS 2400

`endif

// ==== rtl/pmc_pkg.sv ====
// types shared by the port mode control block
`default_nettype none
package pmc_pkg;
  typedef enum logic [2:0] {
    PMC_IDLE,
    PMC_DET,
    PMC_CLS,
    PMC_WAIT,
    PMC_PWR
  } pmc_state_e;

  typedef enum logic [1:0] {
    PMC_I_IDLE,
    PMC_I_ADDR,
    PMC_I_ACK,
    PMC_I_SKIP
  } pmc_i2c_e;

  typedef struct packed {
    logic [3:0] addr;
    logic [3:0] fast_off_n;
    logic midspan;
    logic auto_sel;
    logic uvlo;
    logic thermal;
    logic rst_n;
    logic sda;
    logic scl;
  } pmc_pins_s;

  typedef struct packed {
    logic [3:0] det_ok;
    logic [3:0] cls_end;
    logic [3:0] det_end;
    logic [3:0] powered;
  } pmc_status_s;
endpackage
`default_nettype wire

// ==== rtl/pmc_top.sv ====
// reset sources, per-port mode state machines, serial address responder
//
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
`default_nettype none
`include "pmc_regs.svh"

module pmc_top
  import pmc_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int NPORT = 4,
  parameter int CADENCE_CYCLES = `PMC_CAD_MIN_MS * `PMC_CLK_KHZ
)(
  input wire logic aclk, // device clock
  input wire logic aresetn, // power-up reset, active low
  input wire logic ce, // clock enable
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic serial_clock_line, // serial clock pin
  input wire logic serial_data_input_line, // serial data in pin
  output logic serial_data_output_line_o, // serial data out level
  output logic serial_data_output_line_oe, // serial data out enable
  input wire logic [3:0] slave_address_pins, // low address bits
  input wire logic reset_pin_n, // hardware reset pin
  input wire logic thermal_shutdown, // overtemperature flag
  input wire logic supply_undervoltage, // undervoltage flag
  input wire logic auto_select_pin, // auto or shutdown at reset
  input wire logic cadence_select_pin, // midspan cadence at reset
  input wire logic [NPORT-1:0] port_fast_off_input_n, // fast off pins
  input wire logic [NPORT-1:0] det_done, // detection cycle finished
  input wire logic [NPORT-1:0] det_valid, // detection found valid device
  input wire logic [NPORT-1:0] cls_done, // classification finished
  output logic [NPORT-1:0] det_req, // detection running
  output logic [NPORT-1:0] cls_req, // classification running
  output logic [NPORT-1:0] port_power_on // port power switch on
);
  localparam int CW = $clog2(CADENCE_CYCLES + 1);

  pmc_pins_s pin_raw, pin_s1, pin_s2, pin_s3, pin_st;
  logic [2:0] stretch_reg;
  logic swrst_reg;
  logic dev_rst;
  logic [3:0] addr_cap;
  logic midspan_reg, bypass_reg;
  logic [7:0] mode_reg;
  logic [NPORT-1:0] prst_reg;
  logic [NPORT-1:0] detection_enable, cls_en;
  pmc_status_s stat;

  assign pin_raw = '{addr: slave_address_pins,
                     fast_off_n: port_fast_off_input_n,
                     midspan: cadence_select_pin,
                     auto_sel: auto_select_pin,
                     uvlo: supply_undervoltage,
                     thermal: thermal_shutdown,
                     rst_n: reset_pin_n,
                     sda: serial_data_input_line,
                     scl: serial_clock_line};

  // three stages; a level counts only once stages two and three agree
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
      pin_st <= '0;
    end
    else if (ce)
    begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_st <= (~(pin_s2 ^ pin_s3) & pin_s3) | ((pin_s2 ^ pin_s3) & pin_st);
    end
  end

  // holds reset until the synchronisers carry real pin levels
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      stretch_reg <= `PMC_RST_STRETCH;
    else if (ce && stretch_reg != 3'h0)
      stretch_reg <= stretch_reg - 3'h1;
  end

  assign dev_rst = (stretch_reg != 3'h0) || !pin_st.rst_n || pin_st.thermal
                   || pin_st.uvlo || swrst_reg;

  // pins are re-latched on every reset cycle, frozen afterwards
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      addr_cap <= 4'h0;
    else if (ce && dev_rst)
      addr_cap <= pin_st.addr;
  end

  // AXI4-Lite slave, one write and one read at a time
  logic aw_full, w_full;
  logic [ADDR_W-1:0] aw_addr_reg, ar_addr;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_go;
  logic [7:0] wr_idx, rd_idx, wr_byte;
  logic wr_mode, wr_en, wr_pwr, wr_prst, wr_mid, wr_hicap, wr_map;

  assign s_axi_awready = !aw_full;
  assign s_axi_wready = !w_full;
  assign wr_go = aw_full && w_full && !s_axi_bvalid;
  assign wr_idx = aw_addr_reg[9:2];
  assign wr_byte = w_strb_reg[0] ? w_data_reg[7:0] : 8'h00;
  assign wr_mode = wr_go && w_strb_reg[0] && wr_idx == `PMC_IDX_MODE;
  assign wr_en = wr_go && w_strb_reg[0] && wr_idx == `PMC_IDX_ENABLE;
  assign wr_pwr = wr_go && w_strb_reg[0] && wr_idx == `PMC_IDX_PWRCMD;
  assign wr_prst = wr_go && w_strb_reg[0] && wr_idx == `PMC_IDX_PRESET;
  assign wr_mid = wr_go && w_strb_reg[0] && wr_idx == `PMC_IDX_MIDSPAN;
  assign wr_hicap = wr_go && w_strb_reg[0] && wr_idx == `PMC_IDX_HICAP;
  assign wr_map = wr_idx == `PMC_IDX_MODE || wr_idx == `PMC_IDX_ENABLE
    || wr_idx == `PMC_IDX_PWRCMD || wr_idx == `PMC_IDX_PRESET
    || wr_idx == `PMC_IDX_MIDSPAN || wr_idx == `PMC_IDX_HICAP
    || wr_idx == `PMC_IDX_STATUS;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && !aw_full)
      begin
        aw_full <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full)
      begin
        w_full <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_map && aw_addr_reg[ADDR_W-1:10] == '0)
                       ? 2'h0 : 2'h3;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;
  assign ar_addr = s_axi_araddr;
  assign rd_idx = ar_addr[9:2];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end
    else if (ce)
    begin
      if (s_axi_arvalid && !s_axi_rvalid)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        s_axi_rdata <= 32'h0;
        if (ar_addr[ADDR_W-1:10] != '0)
          s_axi_rresp <= 2'h3;
        else
          case (rd_idx)
            `PMC_IDX_MIDSPAN: s_axi_rdata <= {30'h0, midspan_reg, 1'b0};
            `PMC_IDX_MODE: s_axi_rdata <= {24'h0, mode_reg};
            `PMC_IDX_ENABLE: s_axi_rdata <= {24'h0, cls_en, detection_enable};
            `PMC_IDX_PWRCMD: s_axi_rdata <= 32'h0;
            `PMC_IDX_PRESET: s_axi_rdata <= {27'h0, swrst_reg, prst_reg};
            `PMC_IDX_HICAP: s_axi_rdata <= {27'h0, bypass_reg, 4'h0};
            `PMC_IDX_STATUS: s_axi_rdata <= {16'h0, stat};
            default: s_axi_rresp <= 2'h3;
          endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // global configuration registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_reg <= 8'h00;
      midspan_reg <= 1'b0;
      bypass_reg <= 1'b0;
      swrst_reg <= 1'b0;
    end
    else if (ce)
    begin
      swrst_reg <= wr_prst && wr_byte[`PMC_BIT_SWRST];
      if (dev_rst)
      begin
        mode_reg <= {4{pin_st.auto_sel ? `PMC_MODE_AUTO
                                        : `PMC_MODE_SHUT}};
        midspan_reg <= pin_st.midspan;
        bypass_reg <= 1'b0;
      end
      else
      begin
        if (wr_mode)
          mode_reg <= wr_byte;
        if (wr_mid)
          midspan_reg <= wr_byte[`PMC_BIT_MIDSPAN];
        if (wr_hicap)
          bypass_reg <= wr_byte[`PMC_BIT_BYPASS];
      end
    end
  end

  // port reset bits live for one cycle: the clear is done by then
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      prst_reg <= '0;
    else if (ce)
    begin
      if (dev_rst)
        prst_reg <= '0;
      else if (wr_prst)
        prst_reg <= wr_byte[NPORT-1:0];
      else
        prst_reg <= '0;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NPORT; g++)
    begin : g_port
      logic [1:0] md, md_prev;
      logic enter_auto, enter_man, shut, pon, poff, kill;
      logic detection_enable_r, cls_en_r, det_ok_r, det_end_r, cls_end_r;
      logic det_fin, cls_fin;
      logic [CW-1:0] cad_cnt;
      pmc_state_e st;

      assign md = mode_reg[2*g +: 2];
      assign enter_auto = md == `PMC_MODE_AUTO && md_prev != `PMC_MODE_AUTO;
      assign enter_man = md == `PMC_MODE_MANUAL
                         && md_prev != `PMC_MODE_MANUAL;
      assign shut = md == `PMC_MODE_SHUT;
      assign pon = wr_pwr && wr_byte[g] && !shut;
      assign poff = wr_pwr && wr_byte[4+g];
      assign kill = dev_rst || shut || prst_reg[g] || poff;
      assign det_fin = st == PMC_DET && det_done[g];
      assign cls_fin = st == PMC_CLS && cls_done[g];

      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          md_prev <= 2'h0;
        else if (ce)
          md_prev <= md;
      end

      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          detection_enable_r <= 1'b0;
          cls_en_r <= 1'b0;
        end
        else if (ce)
        begin
          if (dev_rst)
          begin
            detection_enable_r <= pin_st.auto_sel;
            cls_en_r <= pin_st.auto_sel;
          end
          else if (enter_auto)
          begin
            detection_enable_r <= 1'b1;
            cls_en_r <= 1'b1;
          end
          else if (enter_man)
          begin
            detection_enable_r <= 1'b0;
            cls_en_r <= 1'b0;
          end
          else if (wr_en)
          begin
            detection_enable_r <= wr_byte[g];
            cls_en_r <= wr_byte[4+g];
          end
          else if (md == `PMC_MODE_SEMI && (prst_reg[g] || poff))
          begin
            detection_enable_r <= 1'b0;
            cls_en_r <= 1'b0;
          end
          else if (md == `PMC_MODE_MANUAL)
          begin
            if (det_fin)
              detection_enable_r <= 1'b0;
            if (cls_fin)
              cls_en_r <= 1'b0;
          end
        end
      end

      // events and status are cleared only for this port
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          det_end_r <= 1'b0;
          cls_end_r <= 1'b0;
          det_ok_r <= 1'b0;
        end
        else if (ce)
        begin
          if (dev_rst || shut || prst_reg[g])
          begin
            det_end_r <= 1'b0;
            cls_end_r <= 1'b0;
            det_ok_r <= 1'b0;
          end
          // a completion in the port-reset cycle still sets its event
          if (!dev_rst && !shut)
          begin
            if (det_fin)
            begin
              det_end_r <= 1'b1;
              det_ok_r <= det_valid[g];
            end
            if (cls_fin)
              cls_end_r <= 1'b1;
          end
        end
      end

      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          st <= PMC_IDLE;
          cad_cnt <= '0;
        end
        else if (ce)
        begin
          if (kill)
            st <= PMC_IDLE;
          else if (pon)
            st <= PMC_PWR;
          else
            case (st)
              PMC_IDLE:
              begin
                if (detection_enable_r)
                  st <= PMC_DET;
                else if (cls_en_r)
                  st <= PMC_CLS;
                else if (md == `PMC_MODE_AUTO && bypass_reg)
                  st <= PMC_PWR;
              end
              PMC_DET:
              begin
                if (det_done[g])
                begin
                  if (det_valid[g] && cls_en_r)
                    st <= PMC_CLS;
                  else if (det_valid[g] && md == `PMC_MODE_AUTO)
                    st <= PMC_PWR;
                  else if (!det_valid[g] && midspan_reg
                           && md != `PMC_MODE_MANUAL)
                  begin
                    st <= PMC_WAIT;
                    cad_cnt <= '0;
                  end
                  else
                    st <= PMC_IDLE;
                end
              end
              PMC_CLS:
              begin
                if (cls_done[g])
                begin
                  if (md == `PMC_MODE_AUTO
                      && (detection_enable_r ? det_ok_r : bypass_reg))
                    st <= PMC_PWR;
                  else
                    st <= PMC_IDLE;
                end
              end
              PMC_WAIT:
              begin
                if (cad_cnt == CW'(CADENCE_CYCLES - 1))
                  st <= PMC_IDLE;
                else
                  cad_cnt <= cad_cnt + 1'b1;
              end
              PMC_PWR:
              begin
                if (!pin_st.fast_off_n[g])
                  st <= PMC_IDLE;
              end
              default: st <= PMC_IDLE;
            endcase
        end
      end

      assign det_req[g] = st == PMC_DET;
      assign cls_req[g] = st == PMC_CLS;
      assign port_power_on[g] = st == PMC_PWR;
      assign detection_enable[g] = detection_enable_r;
      assign cls_en[g] = cls_en_r;
      assign stat.powered[g] = st == PMC_PWR;
      assign stat.det_end[g] = det_end_r;
      assign stat.cls_end[g] = cls_end_r;
      assign stat.det_ok[g] = det_ok_r;
    end
  endgenerate

  // serial address responder: answers its address byte only
  pmc_i2c_e i_st;
  logic scl_d, sda_d;
  logic [7:0] i_shift;
  logic [3:0] i_cnt;
  logic scl_rise, scl_fall, i_start, i_stop, i_match;

  assign scl_rise = pin_st.scl && !scl_d;
  assign scl_fall = !pin_st.scl && scl_d;
  assign i_start = pin_st.scl && scl_d && !pin_st.sda && sda_d;
  assign i_stop = pin_st.scl && scl_d && pin_st.sda && !sda_d;
  assign i_match = i_shift[7:1] == {`PMC_I2C_ADDR_HI, addr_cap};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      i_st <= PMC_I_IDLE;
      i_shift <= 8'h00;
      i_cnt <= 4'h0;
      serial_data_output_line_oe <= 1'b0;
    end
    else if (ce)
    begin
      scl_d <= pin_st.scl;
      sda_d <= pin_st.sda;
      if (dev_rst || i_stop)
      begin
        i_st <= PMC_I_IDLE;
        serial_data_output_line_oe <= 1'b0;
      end
      // our own ack pull echoes back late and would look like a start
      else if (i_start && i_st != PMC_I_ACK)
      begin
        i_st <= PMC_I_ADDR;
        i_cnt <= 4'h0;
        serial_data_output_line_oe <= 1'b0;
      end
      else
        case (i_st)
          PMC_I_IDLE: serial_data_output_line_oe <= 1'b0;
          PMC_I_ADDR:
          begin
            if (scl_rise)
            begin
              i_shift <= {i_shift[6:0], pin_st.sda};
              i_cnt <= i_cnt + 4'h1;
            end
            else if (scl_fall && i_cnt == 4'h8)
            begin
              i_st <= i_match ? PMC_I_ACK : PMC_I_SKIP;
              serial_data_output_line_oe <= i_match;
            end
          end
          PMC_I_ACK:
          begin
            if (scl_fall)
            begin
              i_st <= PMC_I_SKIP;
              serial_data_output_line_oe <= 1'b0;
            end
          end
          PMC_I_SKIP: serial_data_output_line_oe <= 1'b0;
          default: i_st <= PMC_I_IDLE;
        endcase
    end
  end

  assign serial_data_output_line_o = 1'b0;
endmodule
`default_nettype wire

// ==== test/pmc_props.sv ====
// checker on the port mode control top-level pins
`default_nettype none
module pmc_props #(
  parameter int NPORT = 4
)(
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset
  input wire logic reset_pin_n, // hw reset pin
  input wire logic thermal_shutdown, // overtemp
  input wire logic supply_undervoltage, // uvlo
  input wire logic serial_data_output_line_oe, // ack pull
  input wire logic [NPORT-1:0] det_req, // detecting
  input wire logic [NPORT-1:0] cls_req, // classifying
  input wire logic [NPORT-1:0] port_power_on // powered
);
  timeunit 1ns;
  timeprecision 1ps;
  property p_rst_idle;
    @(posedge aclk) !aresetn |=> port_power_on == '0 && det_req == '0;
  endproperty
  a_rst_idle: assert property (p_rst_idle)
    else $error("port active after reset");
  property p_pin_no_ack;
    @(posedge aclk) disable iff (!aresetn)
      !reset_pin_n [*8] |-> !serial_data_output_line_oe;
  endproperty
  a_pin_no_ack: assert property (p_pin_no_ack)
    else $error("ack while reset pin low");
  property p_uv_no_ack;
    @(posedge aclk) disable iff (!aresetn)
      supply_undervoltage [*8] |-> !serial_data_output_line_oe;
  endproperty
  a_uv_no_ack: assert property (p_uv_no_ack)
    else $error("ack during undervoltage");
  property p_hot_off;
    @(posedge aclk) disable iff (!aresetn)
      thermal_shutdown [*8] |-> port_power_on == '0;
  endproperty
  a_hot_off: assert property (p_hot_off)
    else $error("power on during overtemperature");
  property p_uv_idle;
    @(posedge aclk) disable iff (!aresetn)
      supply_undervoltage [*8] |-> (det_req | port_power_on) == '0;
  endproperty
  a_uv_idle: assert property (p_uv_idle)
    else $error("port busy during undervoltage");
  property p_one_phase;
    @(posedge aclk) disable iff (!aresetn) (det_req & cls_req) == '0;
  endproperty
  a_one_phase: assert property (p_one_phase)
    else $error("detect and classify together");
  property p_power_alone;
    @(posedge aclk) disable iff (!aresetn)
      (port_power_on & (det_req | cls_req)) == '0;
  endproperty
  a_power_alone: assert property (p_power_alone)
    else $error("probing a powered port");
  property p_ack_short;
    @(posedge aclk) disable iff (!aresetn)
      $rose(serial_data_output_line_oe) |-> ##[1:16]
        !serial_data_output_line_oe;
  endproperty
  a_ack_short: assert property (p_ack_short)
    else $error("ack held too long");
endmodule
bind pmc_top pmc_props #(.NPORT(NPORT)) pmc_props_inst (
  .aclk(aclk), .aresetn(aresetn), .reset_pin_n(reset_pin_n),
  .thermal_shutdown(thermal_shutdown),
  .supply_undervoltage(supply_undervoltage),
  .serial_data_output_line_oe(serial_data_output_line_oe),
  .det_req(det_req), .cls_req(cls_req), .port_power_on(port_power_on));
`default_nettype wire

// ==== test/pmc_i2c_host.sv ====
// serial bus master model that addresses the device
`default_nettype none
module pmc_i2c_host (
  output logic scl, // serial clock, idles high
  output logic sda_line, // wired data level
  input wire logic slave_oe, // device drives data
  input wire logic slave_o // level while driving
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sda_m;
  // open drain with pull-up: released line reads high
  assign sda_line = sda_m & (slave_o | !slave_oe);
  initial
  begin
    scl = 1'h1;
    sda_m = 1'h1;
  end
  // data moves 3 device clocks before each rise so the synchroniser sees it
  task automatic send_addr(input logic [6:0] a, output logic acked);
    logic [7:0] b;
    // step off the device clock edge so no pin change races its sampling
    #5;
    b = {a, 1'h0};
    sda_m = 1'h0;
    #100;
    for (int i = 7; i >= 0; i--)
    begin
      scl = 1'h0;
      #25 sda_m = b[i];
      #75 scl = 1'h1;
      #100;
    end
    scl = 1'h0;
    #25 sda_m = 1'h1;
    #75 scl = 1'h1;
    #75 acked = !sda_line;
    #25 scl = 1'h0;
    #25 sda_m = 1'h0;
    #75 scl = 1'h1;
    #100 sda_m = 1'h1;
    #100;
  endtask
endmodule
`default_nettype wire

// ==== test/pmc_top_bench.sv ====
// self-checking bench for the port mode control block
`default_nettype none
`include "pmc_regs.svh"
module pmc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CAD = 20;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, scl, sda, oe, ack, pa, sdo;
  logic rst_pin_n, hot, uv, auto_pin, cad_pin;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [31:0] rnd = 32'h4F9;
  logic [1:0] bresp, rresp;
  logic [3:0] pins, fast_n, det_done, det_valid, cls_done, valid_cfg;
  logic [3:0] det_req, cls_req, pwr;
  logic [33:0] exp_q[$], msk_q[$];
  int errors, checks_done, n;
  pmc_top #(.CADENCE_CYCLES(CAD)) pmc_top_inst (
    .aclk(aclk), .aresetn(aresetn), .ce(1'h1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .serial_clock_line(scl), .serial_data_input_line(sda),
    .serial_data_output_line_o(sdo), .serial_data_output_line_oe(oe),
    .slave_address_pins(pins), .reset_pin_n(rst_pin_n),
    .thermal_shutdown(hot), .supply_undervoltage(uv),
    .auto_select_pin(auto_pin), .cadence_select_pin(cad_pin),
    .port_fast_off_input_n(fast_n), .det_done(det_done),
    .det_valid(det_valid), .cls_done(cls_done), .det_req(det_req),
    .cls_req(cls_req), .port_power_on(pwr));
  pmc_i2c_host pmc_i2c_host_inst (.scl(scl), .sda_line(sda),
    .slave_oe(oe), .slave_o(sdo));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] i, input logic [31:0] d,
    input logic [1:0] r = 2'h0);
    logic a_ok, w_ok;
    exp_q.push_back({r, 32'h0});
    msk_q.push_back({2'h3, 32'h0});
    @(posedge aclk);
    awaddr <= {2'h0, i, 2'h0};
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    a_ok = 1'h0;
    w_ok = 1'h0;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready) a_ok = 1'h1;
      if (wvalid && wready) w_ok = 1'h1;
      if (a_ok) awvalid <= 1'h0;
      if (w_ok) wvalid <= 1'h0;
    end while (!(a_ok && w_ok));
    do @(posedge aclk); while (!bvalid);
    bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] i, input logic [31:0] e,
    input logic [31:0] m, input logic [1:0] r = 2'h0);
    exp_q.push_back({r, e});
    msk_q.push_back({2'h3, m});
    @(posedge aclk);
    araddr <= {2'h0, i, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'h0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'h0;
  endtask
  task automatic cmp(input logic [33:0] v);
    logic [33:0] m;
    m = msk_q.pop_front();
    check(v & m, exp_q.pop_front() & m);
  endtask
  task automatic note(input string s);
    $display("test %0s finished", s);
  endtask
  initial
  begin
    aclk = 1'h0;
    forever #12.5 aclk = ~aclk;
  end
  // far-side measurement units answer after a random number of cycles
  always @(posedge aclk)
  begin
    rnd <= xs(rnd);
    det_valid <= valid_cfg;
    det_done <= det_req & ~det_done & rnd[3:0];
    cls_done <= cls_req & ~cls_done & rnd[7:4];
  end
  always @(posedge aclk)
  begin
    if (bvalid && bready) cmp({bresp, 32'h0});
    if (rvalid && rready) cmp({rresp, rdata});
  end
  initial
  begin
    #(30000 * 25);
    errors++;
    finish_test;
  end
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {hot, uv, auto_pin, cad_pin, pa, valid_cfg} = 9'h0;
    rst_pin_n = 1'h1;
    fast_n = 4'hF;
    awaddr = 12'h0;
    araddr = 12'h0;
    wdata = 32'h0;
    pins = 4'(xs(rnd));
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (12) @(posedge aclk);
    for (int k = 0; k < 4; k++)
    begin
      auto_pin <= k[0];
      cad_pin <= k[1];
      repeat (6) @(posedge aclk);
      rd(`PMC_IDX_MODE, pa ? 32'hFF : 32'h0, 32'hFF);
      case (k)
        0: rst_pin_n <= 1'h0;
        1: hot <= 1'h1;
        2: uv <= 1'h1;
        default: wr(`PMC_IDX_PRESET, 32'h10);
      endcase
      if (k < 3)
      begin
        repeat (2) @(posedge aclk);
        pmc_i2c_host_inst.send_addr({3'h2, pins}, ack);
        check({33'h0, ack}, 34'h0);
        @(posedge aclk);
        {rst_pin_n, hot, uv} <= 3'h4;
      end
      repeat (20) @(posedge aclk);
      rd(`PMC_IDX_MODE, k[0] ? 32'hFF : 32'h0, 32'hFF);
      rd(`PMC_IDX_ENABLE, k[0] ? 32'hFF : 32'h0, 32'hFF);
      rd(`PMC_IDX_MIDSPAN, {30'h0, k[1], 1'h0}, 32'h2);
      pa = k[0];
    end
    note("reset sources");
    while (!det_req[0]) @(posedge aclk);
    while (det_req[0]) @(posedge aclk);
    n = 0;
    while (!det_req[0])
    begin
      @(posedge aclk);
      n++;
    end
    // upper limit is the 2.4 s end of the window scaled from 2 s
    check({33'h0, n >= CAD && n <= CAD * 6 / 5}, 34'h1);
    valid_cfg <= 4'hF;
    repeat (150) @(posedge aclk);
    rd(`PMC_IDX_STATUS, 32'hF, 32'hF);
    wr(`PMC_IDX_MODE, 32'h55);
    rd(`PMC_IDX_STATUS, 32'hF, 32'hF);
    wr(`PMC_IDX_PWRCMD, 32'hF0);
    wr(`PMC_IDX_PRESET, 32'h1);
    wr(`PMC_IDX_ENABLE, 32'h11);
    repeat (60) @(posedge aclk);
    rd(`PMC_IDX_ENABLE, 32'h0, 32'hFF);
    rd(`PMC_IDX_STATUS, 32'h110, 32'h11F);
    wr(`PMC_IDX_PWRCMD, 32'h3);
    rd(`PMC_IDX_STATUS, 32'h3, 32'hF);
    wr(`PMC_IDX_PRESET, 32'h2);
    rd(`PMC_IDX_STATUS, 32'h1111, 32'h3333);
    rd(`PMC_IDX_PRESET, 32'h0, 32'h1F);
    note("manual");
    wr(`PMC_IDX_MODE, 32'hAA);
    wr(`PMC_IDX_ENABLE, 32'hFF);
    repeat (80) @(posedge aclk);
    rd(`PMC_IDX_STATUS, 32'h1, 32'hF);
    wr(`PMC_IDX_PWRCMD, 32'h10);
    rd(`PMC_IDX_ENABLE, 32'hEE, 32'hFF);
    wr(`PMC_IDX_PWRCMD, 32'h2);
    rd(`PMC_IDX_STATUS, 32'h2, 32'hF);
    fast_n <= 4'hD;
    repeat (8) @(posedge aclk);
    fast_n <= 4'hF;
    rd(`PMC_IDX_STATUS, 32'h0, 32'hF);
    rd(`PMC_IDX_ENABLE, 32'hEE, 32'hFF);
    note("semi auto");
    wr(`PMC_IDX_PWRCMD, 32'h4);
    wr(`PMC_IDX_MODE, 32'h0);
    rd(`PMC_IDX_STATUS, 32'h0, 32'hFFFF);
    wr(`PMC_IDX_PWRCMD, 32'hF);
    wr(`PMC_IDX_ENABLE, 32'hFF);
    repeat (20) @(posedge aclk);
    rd(`PMC_IDX_STATUS, 32'h0, 32'hFFFF);
    pmc_i2c_host_inst.send_addr({3'h2, pins}, ack);
    check({33'h0, ack}, 34'h1);
    pmc_i2c_host_inst.send_addr({3'h3, pins}, ack);
    check({33'h0, ack}, 34'h0);
    pmc_i2c_host_inst.send_addr({3'h2, ~pins}, ack);
    check({33'h0, ack}, 34'h0);
    @(posedge aclk);
    rd(8'h0, 32'h0, 32'hFFFFFFFF, 2'h3);
    wr(8'h1, 32'h1, 2'h3);
    note("shutdown and serial");
    repeat (4) @(posedge aclk);
    finish_test;
  end
endmodule
`default_nettype wire
